// *** core_flags_pkg.sv ***
// Constants, field positions and types shared by the core flag and interrupt control logic.
// How it works
// R01: Location 00H redirects through the pointer.
// R02: Pointer at 00H: reads zero, writes dropped.
// R03: Pointer keeps seven bits, bit 7 reads one.
// R04: Working register sits at location 05H.
// R05: Data writes never touch sleep or expiry flags.
// R06: Bit 0 is carry or no-borrow, rotates too.
// R07: Bit 1 is low nibble carry or no-borrow.
// R08: Bit 2 set when the result is zero.
// R09: Bit 3 is carry-in xor carry-out of MSB.
// R10: Sleep and expiry flags follow their events.
// R11: Only the program counter is stacked.
// R12: Control register holds gates and pending flags.
// R13: Falling external pin edge sets bit 4.
// R14: External service calls 04H, clears flag, gate.
// R15: Timer overflow sets bit 5, calls 08H.
// R16: Conversion end sets bit 6, calls 00CH.
// R17: Full stack withholds service, flag stays recorded.
// R18: Interrupt return sets global gate, plain return not.
// R19: Nesting only when software reopens the gates.
// R20: Requests are judged at each phase two pulse.
// R21: Priority external, timer, converter; global gate masks.
// R22: Pending flags stay until serviced or cleared.
// R23: Full stack blocks acknowledge; call overflow drops oldest.
// R24: Acknowledge clears flag and gate in vector cycle.
package core_flags_pkg;

  // Data memory locations handled inside this block.
  localparam logic [6:0] ADDR_INDIRECT = 7'h00;
  localparam logic [6:0] ADDR_POINTER  = 7'h01;
  localparam logic [6:0] ADDR_WORKING  = 7'h05;
  localparam logic [6:0] ADDR_FLAGS    = 7'h0a;
  localparam logic [6:0] ADDR_IRQ_CTRL = 7'h0b;

  // Flag register field positions.
  localparam int FLAG_CARRY = 0;
  localparam int FLAG_HALF  = 1;
  localparam int FLAG_ZERO  = 2;
  localparam int FLAG_WRAP  = 3;
  localparam int FLAG_SLEEP = 4;
  localparam int FLAG_WDT   = 5;

  // Interrupt control register field positions.
  localparam int IRQ_GLOBAL    = 0;
  localparam int IRQ_GATE_LSB  = 1;
  localparam int IRQ_PEND_LSB  = 4;
  localparam int IRQ_SOURCES   = 3;

  // Service vectors, in priority order.
  localparam logic [9:0] VEC_EXT  = 10'h004;
  localparam logic [9:0] VEC_TMR  = 10'h008;
  localparam logic [9:0] VEC_CONV = 10'h00c;

  // Reset values.
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic [6:0] RST_POINTER  = 7'h00;
  localparam logic [2:0] RST_IRQ_BITS = 3'h0;

  // Kind of operation that reports flags.
  typedef enum logic [1:0] {
    ALU_ADD,
    ALU_SUB,
    ALU_LOGIC,
    ALU_ROTC
  } alu_kind_e;

  // Source of a read answer.
  typedef enum logic [1:0] {
    RD_ZERO,
    RD_LOCAL,
    RD_RAM
  } rd_src_e;

endpackage : core_flags_pkg

// *** core_flags_irq.sv ***
// Core control logic: indirect access, working register, flag register and interrupt control.
`timescale 1ns/10ps
`default_nettype none
module core_flags_irq #(
  parameter int ADDR_W = 7 // Data address width; the pointer holds exactly this many bits.
) (
  input  wire logic                       core_clk,
  input  wire logic                       rst_b,
  input  wire logic [ADDR_W-1:0]          mem_addr,
  input  wire logic                       mem_rd,
  input  wire logic                       mem_wr,
  input  wire logic [7:0]                 mem_wdata,
  output logic      [7:0]                 mem_rdata,
  output logic                            mem_rvalid,
  output logic      [ADDR_W-1:0]          ram_addr,
  output logic                            ram_rd,
  output logic                            ram_wr,
  output logic      [7:0]                 ram_wdata,
  input  wire logic [7:0]                 ram_rdata,
  input  wire logic                       work_wr,
  input  wire logic [7:0]                 work_wdata,
  output logic      [7:0]                 working_register,
  input  wire logic                       alu_upd,
  input  wire core_flags_pkg::alu_kind_e  alu_kind,
  input  wire logic [7:0]                 alu_a,
  input  wire logic [7:0]                 alu_b,
  input  wire logic                       alu_cin,
  input  wire logic [7:0]                 alu_result,
  output logic                            carry_flag,
  input  wire logic                       halt_exec,
  input  wire logic                       wdt_clear_instr,
  input  wire logic                       wdt_timeout,
  input  wire logic                       ext_irq_pin,
  input  wire logic                       timer_ovf,
  input  wire logic                       conv_done,
  input  wire logic                       phase_two_pulse,
  input  wire logic                       stack_full,
  input  wire logic                       irq_exit_instr,
  input  wire logic                       subroutine_exit_instr,
  output logic                            irq_take,
  output logic      [9:0]                 irq_vector
);

  // The pointer is stored as seven bits, so only a seven bit address space is served.
  if (ADDR_W != 7)
  begin : g_bad_width
    $error("core_flags_irq: ADDR_W must be 7");
  end

  // State held by the block.
  logic [ADDR_W-1:0]     indirect_pointer_r;   // Indirect pointer, seven bits kept.
  logic [7:0]            working_register_r;   // Working register.
  logic                  carry_flag_r;         // Carry or no-borrow.
  logic                  half_nibble_flag_r;   // Low nibble carry.
  logic                  zero_flag_r;          // Zero result.
  logic                  signed_wrap_flag_r;   // Signed overflow.
  logic                  sleep_entered_flag_r; // Set by halt.
  logic                  wdt_expiry_flag_r;    // Set by watchdog timeout.
  logic                  global_irq_gate_r;    // Master interrupt gate.
  logic [2:0]            src_gate_r;           // Per source gates: ext, timer, converter.
  logic [2:0]            src_pend_r;           // Per source pending flags.
  logic                  ext_pin_d_r;          // Previous external pin level.
  core_flags_pkg::rd_src_e rd_src_r;           // Answer source of the read in flight.
  logic                  rd_pend_r;            // A read is in flight.
  logic [7:0]            local_val_r;          // Captured local register value.
  logic [7:0]            mem_rdata_r;
  logic                  mem_rvalid_r;
  logic [ADDR_W-1:0]     ram_addr_r;
  logic                  ram_rd_r;
  logic                  ram_wr_r;
  logic [7:0]            ram_wdata_r;
  logic                  irq_take_r;
  logic [9:0]            irq_vector_r;

  // Address redirection through the indirect pointer.
  wire                   is_indirect = (mem_addr == core_flags_pkg::ADDR_INDIRECT); // R01
  wire                   null_ind    = is_indirect && (indirect_pointer_r == 7'h00); // R02
  wire [ADDR_W-1:0]      eff_addr    = is_indirect ? indirect_pointer_r : mem_addr;  // R01
  wire                   hit_ptr     = (eff_addr == core_flags_pkg::ADDR_POINTER);
  wire                   hit_work    = (eff_addr == core_flags_pkg::ADDR_WORKING);   // R04
  wire                   hit_flags   = (eff_addr == core_flags_pkg::ADDR_FLAGS);
  wire                   hit_irqc    = (eff_addr == core_flags_pkg::ADDR_IRQ_CTRL);
  wire                   hit_local   = hit_ptr || hit_work || hit_flags || hit_irqc;
  wire                   wr_ok       = mem_wr && !null_ind;                          // R02
  wire                   wr_ptr      = wr_ok && hit_ptr;
  wire                   wr_work     = wr_ok && hit_work;
  wire                   wr_flags    = wr_ok && hit_flags;
  wire                   wr_irqc     = wr_ok && hit_irqc;

  // Register images as software reads them.
  wire [7:0] ptr_img   = {1'b1, indirect_pointer_r};                                // R03
  wire [7:0] flags_img = {2'b00, wdt_expiry_flag_r, sleep_entered_flag_r,
                          signed_wrap_flag_r, zero_flag_r, half_nibble_flag_r, carry_flag_r}; // R10
  wire [7:0] irqc_img  = {1'b0, src_pend_r, src_gate_r, global_irq_gate_r};         // R12
  wire [7:0] local_sel = hit_ptr   ? ptr_img :
                         hit_work  ? working_register_r :
                         hit_flags ? flags_img : irqc_img;

  // Flag arithmetic: subtraction adds the inverted operand, so carry means no borrow.
  wire       is_sub  = (alu_kind == core_flags_pkg::ALU_SUB);
  wire [7:0] b_eff   = is_sub ? ~alu_b : alu_b;
  wire [4:0] lo_sum  = {1'b0, alu_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, alu_cin};
  wire [7:0] low7sum = {1'b0, alu_a[6:0]} + {1'b0, b_eff[6:0]} + {7'h00, alu_cin};
  wire [8:0] full    = {1'b0, alu_a} + {1'b0, b_eff} + {8'h00, alu_cin};
  wire       is_arith = (alu_kind == core_flags_pkg::ALU_ADD) || is_sub;
  wire       is_rot   = (alu_kind == core_flags_pkg::ALU_ROTC);

  // Next values of the four arithmetic flags.
  logic carry_nxt;
  logic half_nxt;
  logic zero_nxt;
  logic wrap_nxt;

  // A data write to the flag register wins over a flag report in the same cycle.
  always_comb
  begin
    carry_nxt = carry_flag_r;
    half_nxt  = half_nibble_flag_r;
    zero_nxt  = zero_flag_r;
    wrap_nxt  = signed_wrap_flag_r;
    if (wr_flags)
    begin
      // Only the arithmetic flags take data; sleep and expiry are left alone.
      carry_nxt = mem_wdata[core_flags_pkg::FLAG_CARRY];
      half_nxt  = mem_wdata[core_flags_pkg::FLAG_HALF];
      zero_nxt  = mem_wdata[core_flags_pkg::FLAG_ZERO];
      wrap_nxt  = mem_wdata[core_flags_pkg::FLAG_WRAP];
    end
    else if (alu_upd)
    begin
      if (is_arith)
      begin
        carry_nxt = full[8];                 // R06
        half_nxt  = lo_sum[4];               // R07
        wrap_nxt  = low7sum[7] ^ full[8];    // R09
      end
      if (is_rot)
      begin
        // The bit rotated out arrives on the carry input.
        carry_nxt = alu_cin;                 // R06
      end
      if (!is_rot)
      begin
        zero_nxt = (alu_result == 8'h00);    // R08
      end
    end
  end

  // Arithmetic flags.
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      carry_flag_r       <= 1'b0;
      half_nibble_flag_r <= 1'b0;
      zero_flag_r        <= 1'b0;
      signed_wrap_flag_r <= 1'b0;
    end
    else
    begin
      carry_flag_r       <= carry_nxt;
      half_nibble_flag_r <= half_nxt;
      zero_flag_r        <= zero_nxt;
      signed_wrap_flag_r <= wrap_nxt;
    end
  end

  // Sleep and expiry flags: only their own events move them, the set wins over the clear.
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sleep_entered_flag_r <= 1'b0;
      wdt_expiry_flag_r    <= 1'b0;
    end
    else
    begin
      sleep_entered_flag_r <= halt_exec || (sleep_entered_flag_r && !wdt_clear_instr);         // R10 R05
      wdt_expiry_flag_r    <= wdt_timeout || (wdt_expiry_flag_r && !wdt_clear_instr && !halt_exec); // R10 R05
    end
  end

  // Pointer and working register; a data write beats the datapath write to the working register.
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      indirect_pointer_r <= core_flags_pkg::RST_POINTER;
      working_register_r <= core_flags_pkg::RST_BYTE;
    end
    else
    begin
      if (wr_ptr)
      begin
        indirect_pointer_r <= mem_wdata[ADDR_W-1:0]; // R03
      end
      if (wr_work)
      begin
        working_register_r <= mem_wdata;             // R04
      end
      else if (work_wr)
      begin
        working_register_r <= work_wdata;
      end
    end
  end

  // Read pipeline, first stage: decide where the answer comes from and forward to the RAM.
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rd_pend_r   <= 1'b0;
      rd_src_r    <= core_flags_pkg::RD_ZERO;
      local_val_r <= core_flags_pkg::RST_BYTE;
      ram_addr_r  <= '0;
      ram_rd_r    <= 1'b0;
      ram_wr_r    <= 1'b0;
      ram_wdata_r <= core_flags_pkg::RST_BYTE;
    end
    else
    begin
      rd_pend_r   <= mem_rd;
      rd_src_r    <= null_ind  ? core_flags_pkg::RD_ZERO :   // R02
                     hit_local ? core_flags_pkg::RD_LOCAL : core_flags_pkg::RD_RAM;
      local_val_r <= local_sel;
      ram_addr_r  <= eff_addr;                               // R01
      ram_rd_r    <= mem_rd && !null_ind && !hit_local;
      ram_wr_r    <= wr_ok && !hit_local;                    // R02
      ram_wdata_r <= mem_wdata;
    end
  end

  // Read pipeline, second stage: the RAM answers combinationally during its strobe cycle.
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mem_rvalid_r <= 1'b0;
      mem_rdata_r  <= core_flags_pkg::RST_BYTE;
    end
    else
    begin
      mem_rvalid_r <= rd_pend_r;
      // Only a read in flight loads the answer, so the byte holds between answers and never
      // picks up whatever an idle RAM bus happens to show.
      if (rd_pend_r)
      begin
        unique case (rd_src_r)
          core_flags_pkg::RD_ZERO:  mem_rdata_r <= 8'h00;       // R02
          core_flags_pkg::RD_LOCAL: mem_rdata_r <= local_val_r;
          core_flags_pkg::RD_RAM:   mem_rdata_r <= ram_rdata;
          default:                  mem_rdata_r <= 8'h00;
        endcase
      end
    end
  end

  // Interrupt request evaluation, done only at the phase two pulse.
  wire [2:0] src_evt  = {conv_done, timer_ovf, ext_pin_d_r && !ext_irq_pin}; // R13 R15 R16
  wire [2:0] src_req  = src_gate_r & src_pend_r;
  wire       ack      = phase_two_pulse && global_irq_gate_r && (|src_req) && !stack_full; // R20 R17 R23 R19
  wire [2:0] ack_mask = !ack       ? 3'b000 :
                        src_req[0] ? 3'b001 :
                        src_req[1] ? 3'b010 : 3'b100;                         // R21
  wire [9:0] ack_vec  = src_req[0] ? core_flags_pkg::VEC_EXT :                // R14
                        src_req[1] ? core_flags_pkg::VEC_TMR :                // R15
                                     core_flags_pkg::VEC_CONV;                // R16

  // Per source gate and pending flag; a new event wins over any clear in the same cycle.
  for (genvar s = 0; s < core_flags_pkg::IRQ_SOURCES; s++)
  begin : g_src
    always_ff @(posedge core_clk or negedge rst_b)
    begin
      if (!rst_b)
      begin
        src_gate_r[s] <= 1'b0;
        src_pend_r[s] <= 1'b0;
      end
      else
      begin
        if (wr_irqc)
        begin
          src_gate_r[s] <= mem_wdata[core_flags_pkg::IRQ_GATE_LSB + s];
        end
        if (src_evt[s])
        begin
          src_pend_r[s] <= 1'b1;                                               // R13 R22
        end
        else if (ack_mask[s])
        begin
          src_pend_r[s] <= 1'b0;                                               // R24
        end
        else if (wr_irqc)
        begin
          src_pend_r[s] <= mem_wdata[core_flags_pkg::IRQ_PEND_LSB + s];        // R22
        end
      end
    end
  end

  // Master gate: the acknowledge closes it in the vector cycle so a second one cannot follow.
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      global_irq_gate_r <= 1'b0;
      ext_pin_d_r       <= 1'b1;
    end
    else
    begin
      ext_pin_d_r <= ext_irq_pin;
      if (ack)
      begin
        global_irq_gate_r <= 1'b0;                                             // R24
      end
      else if (irq_exit_instr)
      begin
        global_irq_gate_r <= 1'b1;                                             // R18
      end
      else if (wr_irqc)
      begin
        global_irq_gate_r <= mem_wdata[core_flags_pkg::IRQ_GLOBAL];            // R19
      end
    end
  end

  // Vector to the sequencer; it pushes only the program counter, never the flags.
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irq_take_r   <= 1'b0;
      irq_vector_r <= 10'h000;
    end
    else
    begin
      irq_take_r <= ack;                                                       // R11 R24
      if (ack)
      begin
        irq_vector_r <= ack_vec;
      end
    end
  end

  // Outputs straight from flip-flops.
  assign mem_rdata        = mem_rdata_r;
  assign mem_rvalid       = mem_rvalid_r;
  assign ram_addr         = ram_addr_r;
  assign ram_rd           = ram_rd_r;
  assign ram_wr           = ram_wr_r;
  assign ram_wdata        = ram_wdata_r;
  assign working_register = working_register_r;
  assign carry_flag       = carry_flag_r;
  assign irq_take         = irq_take_r;
  assign irq_vector       = irq_vector_r;

  // Assertions.
  sequence s_null_read;
    mem_rd && is_indirect && (indirect_pointer_r == 7'h00);
  endsequence

  sequence s_answer_zero;
    ##2 mem_rvalid && (mem_rdata == 8'h00);
  endsequence

  property p_null_read;
    @(posedge core_clk) disable iff (!rst_b)
    s_null_read |-> s_answer_zero;
  endproperty
  a_null_read: assert property (p_null_read) else $error("indirect read via zero pointer not zero"); // R02

  property p_null_write;
    @(posedge core_clk) disable iff (!rst_b)
    (mem_wr && null_ind) |=> !ram_wr && $stable(working_register) && $stable(irqc_img);
  endproperty
  a_null_write: assert property (p_null_write) else $error("indirect write via zero pointer had effect"); // R02

  property p_redirect;
    @(posedge core_clk) disable iff (!rst_b)
    (mem_wr && is_indirect && !null_ind && !hit_local) |=> ram_wr && (ram_addr == $past(indirect_pointer_r));
  endproperty
  a_redirect: assert property (p_redirect) else $error("indirect write not redirected"); // R01

  property p_pointer_read;
    @(posedge core_clk) disable iff (!rst_b)
    (mem_rd && !is_indirect && (mem_addr == core_flags_pkg::ADDR_POINTER)) |-> ##2 mem_rvalid && mem_rdata[7];
  endproperty
  a_pointer_read: assert property (p_pointer_read) else $error("pointer bit 7 not read as one"); // R03

  property p_flag_write_keeps;
    @(posedge core_clk) disable iff (!rst_b)
    (wr_flags && !halt_exec && !wdt_clear_instr && !wdt_timeout) |=> $stable(sleep_entered_flag_r) && $stable(wdt_expiry_flag_r);
  endproperty
  a_flag_write_keeps: assert property (p_flag_write_keeps) else $error("data write moved sleep or expiry flag"); // R05

  property p_add_carry;
    @(posedge core_clk) disable iff (!rst_b)
    (alu_upd && !wr_flags && (alu_kind == core_flags_pkg::ALU_ADD)) |=>
      (carry_flag == (({1'b0, $past(alu_a)} + {1'b0, $past(alu_b)} + {8'h00, $past(alu_cin)}) > 9'h0ff));
  endproperty
  a_add_carry: assert property (p_add_carry) else $error("carry flag wrong after addition"); // R06

  property p_ext_edge;
    @(posedge core_clk) disable iff (!rst_b)
    (ext_pin_d_r && !ext_irq_pin) |=> src_pend_r[0];
  endproperty
  a_ext_edge: assert property (p_ext_edge) else $error("falling edge did not set external pending"); // R13

  property p_full_stack;
    @(posedge core_clk) disable iff (!rst_b)
    (phase_two_pulse && stack_full) |=> !irq_take;
  endproperty
  a_full_stack: assert property (p_full_stack) else $error("acknowledge given with full stack"); // R17

  property p_take_clears;
    @(posedge core_clk) disable iff (!rst_b)
    irq_take |-> !global_irq_gate_r ##1 !irq_take;
  endproperty
  a_take_clears: assert property (p_take_clears) else $error("gate still open after acknowledge"); // R24

  property p_priority;
    @(posedge core_clk) disable iff (!rst_b)
    (irq_take && (irq_vector != core_flags_pkg::VEC_EXT)) |-> !$past(src_req[0]);
  endproperty
  a_priority: assert property (p_priority) else $error("lower priority served before external"); // R21

  property p_return_opens;
    @(posedge core_clk) disable iff (!rst_b)
    (irq_exit_instr && !ack) |=> global_irq_gate_r;
  endproperty
  a_return_opens: assert property (p_return_opens) else $error("interrupt return did not open gate"); // R18

  // A plain return alone must leave the master gate where it was.
  property p_plain_return;
    @(posedge core_clk) disable iff (!rst_b)
    (subroutine_exit_instr && !irq_exit_instr && !ack && !wr_irqc) |=> $stable(global_irq_gate_r);
  endproperty
  a_plain_return: assert property (p_plain_return) else $error("plain return moved the global gate"); // R18

endmodule : core_flags_irq
`default_nettype wire

// *** ram_model.sv ***
// Behavioural data memory that answers the block's external RAM port.
`timescale 1ns/10ps
`default_nettype none
module ram_model (
  input  wire logic       core_clk,
  input  wire logic [6:0] ram_addr,
  input  wire logic       ram_rd,
  input  wire logic       ram_wr,
  input  wire logic [7:0] ram_wdata,
  output logic      [7:0] ram_rdata
);
  logic [7:0] mem [128]; // Storage for every data address.
  logic [7:0] last_r;    // Last byte handed out.

  // The answer is valid only while the strobe is high.
  // Once the strobe drops, the bus shows the inverse of the last byte, so a late sample can never pass by luck.
  assign ram_rdata = ram_rd ? mem[ram_addr] : ~last_r;

  // Writes land at the edge that ends the strobe cycle. This is the target of the redirected accesses.
  always_ff @(posedge core_clk)
  begin
    if (ram_wr)
    begin
      mem[ram_addr] <= ram_wdata;
    end
    if (ram_rd)
    begin
      last_r <= mem[ram_addr];
    end
  end
endmodule : ram_model
`default_nettype wire

// *** tb_core_flags_and_interrupt_control.sv ***
// Self-checking bench for the flag, indirect access and interrupt control block.
`timescale 1ns/10ps
`default_nettype none
module tb_core_flags_and_interrupt_control;
  logic                      core_clk, rst_b, mem_rd, mem_wr, work_wr, alu_upd, alu_cin, ext_irq_pin, stack_full;
  logic [6:0]                mem_addr, ram_addr;
  logic [7:0]                mem_wdata, work_wdata, alu_a, alu_b, alu_result, ram_rdata, ram_wdata;
  logic [7:0]                mem_rdata, working_register;
  logic                      mem_rvalid, ram_rd, ram_wr, carry_flag, irq_take;
  logic [9:0]                irq_vector;
  core_flags_pkg::alu_kind_e alu_kind;
  // Pulses: halt, wdt clear, timeout, timer, conversion, irq exit, plain exit, phase two.
  logic [7:0]                evv;
  int                        bad_count, check_count;

  core_flags_irq dut (.core_clk, .rst_b, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata, .mem_rvalid,
    .ram_addr, .ram_rd, .ram_wr, .ram_wdata, .ram_rdata, .work_wr, .work_wdata, .working_register, .alu_upd,
    .alu_kind, .alu_a, .alu_b, .alu_cin, .alu_result, .carry_flag, .halt_exec(evv[0]), .wdt_clear_instr(evv[1]),
    .wdt_timeout(evv[2]), .ext_irq_pin, .timer_ovf(evv[3]), .conv_done(evv[4]), .phase_two_pulse(evv[7]),
    .stack_full, .irq_exit_instr(evv[5]), .subroutine_exit_instr(evv[6]), .irq_take, .irq_vector);
  ram_model ram (.core_clk, .ram_addr, .ram_rd, .ram_wr, .ram_wdata, .ram_rdata);

  // Free-running 25 MHz clock.
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Prints the counts and the verdict, then stops the run.
  task automatic summarize();
    $display("Checks %0d, errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize

  // Compares one result; case inequality lets no unknown pass.
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One write cycle; writes give no answer.
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge core_clk);
    mem_addr = a;
    mem_wdata = d;
    mem_wr = 1'b1;
    @(negedge core_clk);
    mem_wr = 1'b0;
  endtask : wr

  // One read cycle; the answer pulse stands between the first and second edges after the request edge,
  // so it is looked at on the falling edge in between.
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    @(negedge core_clk);
    mem_addr = a;
    mem_rd = 1'b1;
    @(negedge core_clk);
    mem_rd = 1'b0;
    @(negedge core_clk);
    chk({2'b00, mem_rvalid, mem_rdata}, {3'b001, e});
  endtask : rd

  // Pulses one event line for a single cycle.
  task automatic ev(input int i);
    @(negedge core_clk);
    evv[i] = 1'b1;
    @(negedge core_clk);
    evv = 8'h00;
  endtask : ev

  // One flag-reporting operation, then the flag byte is read back.
  task automatic alu(input core_flags_pkg::alu_kind_e k, input logic [7:0] a, b, input logic c,
                     input logic [7:0] r, e);
    @(negedge core_clk);
    alu_kind = k;
    {alu_a, alu_b, alu_cin, alu_result, alu_upd} = {a, b, c, r, 1'b1};
    @(negedge core_clk);
    alu_upd = 1'b0;
    rd(7'h0a, e);
  endtask : alu

  // A phase-two pulse with the given stack level; the take and vector are seen in the next cycle.
  task automatic p2(input logic sf, input logic t, input logic [9:0] v);
    @(negedge core_clk);
    stack_full = sf;
    evv[7] = 1'b1;
    @(negedge core_clk);
    evv[7] = 1'b0;
    chk({irq_take, irq_vector}, {t, v});
  endtask : p2

  // Cuts a hang short; the full sequence needs well under a tenth of this span.
  initial
  begin
    #100000;
    bad_count++;
    summarize();
  end

  // Main sequence.
  initial
  begin
    {mem_rd, mem_wr, work_wr, alu_upd, alu_cin, stack_full, rst_b} = 7'h00;
    {mem_addr, mem_wdata, work_wdata, alu_a, alu_b, alu_result, evv} = 55'h0;
    alu_kind = core_flags_pkg::ALU_ADD;
    ext_irq_pin = 1'b1;
    repeat (20) @(posedge core_clk);
    @(negedge core_clk);
    rst_b = 1'b1;
    rd(7'h01, 8'h80);
    rd(7'h0a, 8'h00);
    rd(7'h0b, 8'h00);
    alu(core_flags_pkg::ALU_ADD, 8'hff, 8'h01, 1'b0, 8'h00, 8'h07);
    chk({10'h000, carry_flag}, 11'h001);
    alu(core_flags_pkg::ALU_ADD, 8'h7f, 8'h01, 1'b0, 8'h80, 8'h0a);
    alu(core_flags_pkg::ALU_SUB, 8'h05, 8'h03, 1'b1, 8'h02, 8'h03);
    alu(core_flags_pkg::ALU_LOGIC, 8'h0f, 8'hf0, 1'b0, 8'h00, 8'h07);
    alu(core_flags_pkg::ALU_ROTC, 8'h00, 8'h00, 1'b0, 8'h00, 8'h06);
    chk({10'h000, carry_flag}, 11'h000);
    wr(7'h0a, 8'hff);
    rd(7'h0a, 8'h0f);
    ev(0);
    rd(7'h0a, 8'h1f);
    ev(2);
    rd(7'h0a, 8'h3f);
    wr(7'h0a, 8'h00);
    rd(7'h0a, 8'h30);
    ev(0);
    rd(7'h0a, 8'h10);
    ev(1);
    rd(7'h0a, 8'h00);
    wr(7'h01, 8'hff);
    rd(7'h01, 8'hff);
    wr(7'h01, 8'h45);
    wr(7'h00, 8'h5a);
    rd(7'h00, 8'h5a);
    rd(7'h45, 8'h5a);
    wr(7'h01, 8'h00);
    wr(7'h00, 8'h33);
    rd(7'h00, 8'h00);
    wr(7'h05, 8'h3c);
    chk({3'b000, working_register}, 11'h03c);
    @(negedge core_clk);
    {work_wr, work_wdata} = 9'h111;
    @(negedge core_clk);
    work_wr = 1'b0;
    rd(7'h05, 8'h11);
    wr(7'h0b, 8'h0f);
    @(negedge core_clk);
    ext_irq_pin = 1'b0;
    ev(3);
    ev(4);
    rd(7'h0b, 8'h7f);
    p2(1'b1, 1'b0, 10'h000);
    rd(7'h0b, 8'h7f);
    p2(1'b0, 1'b1, 10'h004);
    rd(7'h0b, 8'h6e);
    p2(1'b0, 1'b0, 10'h004);
    ev(5);
    p2(1'b0, 1'b1, 10'h008);
    rd(7'h0b, 8'h4e);
    ev(6);
    p2(1'b0, 1'b0, 10'h008);
    wr(7'h0b, 8'h4f);
    p2(1'b0, 1'b1, 10'h00c);
    rd(7'h0b, 8'h0e);
    // A pending flag stays with the gate closed, and a software clear keeps it from being served.
    ev(3);
    rd(7'h0b, 8'h2e);
    wr(7'h0b, 8'h0f);
    p2(1'b0, 1'b0, 10'h00c);
    summarize();
  end
endmodule : tb_core_flags_and_interrupt_control
`default_nettype wire
